/* File: design/fgra_params.svh */
// Offsets, field positions, reset values and command codes of the gauge register block.
// Assumes inclusion by bare name from the design files; holds definitions only.
`ifndef FGRA_PARAMS_SVH
`define FGRA_PARAMS_SVH
`define FGRA_SLAVE_ADDR 7'h36
`define FGRA_OFS_CONTROL 8'h06
`define FGRA_OFS_ID 8'h08
`define FGRA_OFS_STATUS 8'h0a
`define FGRA_OFS_RATE 8'h0b
`define FGRA_OFS_COMP 8'h0c
`define FGRA_OFS_CONFIG 8'h0d
`define FGRA_OFS_FACTORY 8'hfe
`define FGRA_CMD_QUICK_SENSE 16'h4000
`define FGRA_CMD_INIT 16'h5400
`define FGRA_RST_COMP 8'h32
`define FGRA_RST_THR 5'h1c
`define FGRA_THR_BASE 8'h20
`define FGRA_BIT_STEP 5
`define FGRA_BIT_LOW 4
`define FGRA_BIT_PUP 0
`define FGRA_BIT_SLEEP 7
`define FGRA_BIT_STEP_EN 6
`define FGRA_BIT_ALERT 5
`define FGRA_PIN_SCL 0
`define FGRA_PIN_SDA 1
`define FGRA_PIN_QS 2
`endif

/* File: design/fgra_pkg.sv */
// Types of the gauge register block.
// Assumes nothing of its surroundings.
`default_nettype none
package fgra_pkg;
    typedef enum logic [8:0] {
        fgra_st_idle = 9'h001,
        fgra_st_addr = 9'h002,
        fgra_st_aack = 9'h004,
        fgra_st_cmd = 9'h008,
        fgra_st_cack = 9'h010,
        fgra_st_wdata = 9'h020,
        fgra_st_wack = 9'h040,
        fgra_st_rdata = 9'h080,
        fgra_st_rack = 9'h100
    } fgra_state_t;
endpackage
`default_nettype wire

/* File: design/fgra_pin_if.sv */
// Synchronised pin levels and their edges, passed from the synchroniser to the gauge block.
// Assumes both ends run on mclk.
`timescale 1ns/100ps
`default_nettype none
interface fgra_pin_if #(parameter int N = 3);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src (output level, rise, fall);
    modport dst (input level, rise, fall);
endinterface
`default_nettype wire

/* File: design/fgra_sync.sv */
// Two-stage synchronisers with edge detection for the asynchronous pins.
// Assumes raw inputs are asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module fgra_sync #(parameter int N = 3) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [N-1:0] raw,
    fgra_pin_if.src pins
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // The first stage is read by the second stage only.
            always_ff @(posedge mclk) begin
                if (reset) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                end else begin
                    s1 <= raw[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign pins.level[i] = s2;
            assign pins.rise[i] = s2 & ~s3;
            assign pins.fall[i] = ~s2 & s3;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: design/fgra_gauge_regs.sv */
// Gauge register block: two-wire slave, command, identity, rate, configuration and alert logic.
// Assumes an estimation core on mclk supplies charge level and step events; pins are asynchronous.
//
// Functional notes
// - Word 4000h written to the command register restarts sensing as at power-up.
// - Any other command value is reserved and performs nothing.
// - Identity register is read-only with a fixed value.
// - Charge-rate register is read-only, one count per 1% per hour.
// - Byte 0Ch is the compensation value, 32h at reset, host-writable.
// - Bit 7 of byte 0Dh controls sleep, cleared at reset.
// - Bit 6 of byte 0Dh enables the charge-step alert, cleared at reset.
// - With step alert enabled, each 1% charge move sets the charge-step flag.
// - Bit 5 of byte 0Dh is the alert summary, cleared by host zero or reset.
// - Bits 4-0 of byte 0Dh give threshold percent as 32 minus field.
// - Threshold field resets to 1Ch, meaning 4%.
// - Any status alert flag being set also sets the alert summary.
// - Charge-step flag is status bit 5, sticky until host zero or reset.
// - Low-charge flag is status bit 4, set below threshold, sticky.
// - Power-up flag is status bit 0, set by reset, host-clearable.
// - Respond only to seven-bit slave address 0110110.
// - Bytes are eight bits MSB first, then one acknowledge bit.
// - Factory command register is write-only and accepts 5400h.
// - The factory initialisation command acts as a power-on reset for everything except its own pulse and the pin synchronisers.
// - Writes take effect only after all 16 data bits; partial writes vanish.
// - Alert pin is driven low while the alert is pending; sleep keeps it.
// - A rising edge on the quick-sense pin restarts sensing like the command.
`timescale 1ns/100ps
`default_nettype none
`include "fgra_params.svh"
module fgra_gauge_regs #(
    // Arbitrary identity value.
    parameter logic [15:0] ID_VALUE = 16'h1357
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic restart_sense_input,
    output logic alert_out,
    output logic alert_oe,
    input wire logic [7:0] charge_level,
    input wire logic charge_step_event,
    input wire logic [7:0] charge_rate,
    output logic restart_sense,
    output logic device_init,
    output logic sleep_mode,
    output logic [7:0] compensation_param
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    fgra_pin_if #(.N(3)) pins ();
    fgra_sync #(.N(3)) u_sync (
        .mclk(mclk),
        .reset(reset),
        .raw({restart_sense_input, sda_in, scl_in}),
        .pins(pins)
    );

    fgra_pkg::fgra_state_t state;
    logic rst_all;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic start;
    logic stop;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] hi;
    logic have_hi;
    logic rw;
    logic nack;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [15:0] wr_word;
    logic [7:0] rd_byte;
    logic step_en;
    logic alert_sum;
    logic [4:0] thr;
    logic step_flag;
    logic low_flag;
    logic pup_flag;
    logic below;
    logic below_q;
    logic set_step;
    logic set_low;
    logic wr_status;
    logic wr_config;
    logic [7:0] low_pct;

    // The factory initialisation pulse resets everything but itself and the pin synchronisers.
    assign rst_all = reset | device_init;
    assign scl_rise = pins.rise[`FGRA_PIN_SCL];
    assign scl_fall = pins.fall[`FGRA_PIN_SCL];
    assign sda = pins.level[`FGRA_PIN_SDA];
    assign start = pins.fall[`FGRA_PIN_SDA] & pins.level[`FGRA_PIN_SCL];
    assign stop = pins.rise[`FGRA_PIN_SDA] & pins.level[`FGRA_PIN_SCL];
    assign sda_out = 1'b0;

    // ----------------------------------------------------------------
    // Two-wire slave engine
    // ----------------------------------------------------------------
    // Bits are sampled on the synchronised rising clock edge and driven after the falling one,
    // so the data line never changes while the clock is high.
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            state <= fgra_pkg::fgra_st_idle;
            cnt <= 4'h0;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            hi <= 8'h00;
            have_hi <= 1'b0;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start) begin
            state <= fgra_pkg::fgra_st_addr;
            cnt <= 4'h0;
            have_hi <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop) begin
            state <= fgra_pkg::fgra_st_idle;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (state == fgra_pkg::fgra_st_addr || state == fgra_pkg::fgra_st_cmd ||
                state == fgra_pkg::fgra_st_wdata) begin
                shreg <= {shreg[6:0], sda};
                cnt <= cnt + 4'h1;
            end
            if (state == fgra_pkg::fgra_st_rack) begin
                nack <= sda;
            end
        end else if (scl_fall) begin
            case (state)
                fgra_pkg::fgra_st_addr: begin
                    if (cnt == 4'h8) begin
                        if (shreg[7:1] == `FGRA_SLAVE_ADDR) begin
                            state <= fgra_pkg::fgra_st_aack;
                            rw <= shreg[0];
                            sda_oe <= 1'b1;
                        end else begin
                            state <= fgra_pkg::fgra_st_idle;
                        end
                    end
                end
                fgra_pkg::fgra_st_aack: begin
                    if (rw) begin
                        state <= fgra_pkg::fgra_st_rdata;
                        tx <= {rd_byte[6:0], 1'b0};
                        sda_oe <= ~rd_byte[7];
                        cnt <= 4'h1;
                    end else begin
                        state <= fgra_pkg::fgra_st_cmd;
                        sda_oe <= 1'b0;
                        cnt <= 4'h0;
                    end
                end
                fgra_pkg::fgra_st_cmd: begin
                    if (cnt == 4'h8) begin
                        state <= fgra_pkg::fgra_st_cack;
                        ptr <= shreg;
                        sda_oe <= 1'b1;
                    end
                end
                fgra_pkg::fgra_st_cack: begin
                    state <= fgra_pkg::fgra_st_wdata;
                    sda_oe <= 1'b0;
                    cnt <= 4'h0;
                    have_hi <= 1'b0;
                end
                fgra_pkg::fgra_st_wdata: begin
                    if (cnt == 4'h8) begin
                        state <= fgra_pkg::fgra_st_wack;
                        sda_oe <= 1'b1;
                        have_hi <= ~have_hi;
                        if (have_hi) begin
                            ptr <= ptr + 8'h02;
                        end else begin
                            hi <= shreg;
                        end
                    end
                end
                fgra_pkg::fgra_st_wack: begin
                    state <= fgra_pkg::fgra_st_wdata;
                    sda_oe <= 1'b0;
                    cnt <= 4'h0;
                end
                fgra_pkg::fgra_st_rdata: begin
                    if (cnt == 4'h8) begin
                        state <= fgra_pkg::fgra_st_rack;
                        sda_oe <= 1'b0;
                        ptr <= ptr + 8'h01;
                    end else begin
                        sda_oe <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                        cnt <= cnt + 4'h1;
                    end
                end
                fgra_pkg::fgra_st_rack: begin
                    if (nack) begin
                        state <= fgra_pkg::fgra_st_idle;
                    end else begin
                        state <= fgra_pkg::fgra_st_rdata;
                        tx <= {rd_byte[6:0], 1'b0};
                        sda_oe <= ~rd_byte[7];
                        cnt <= 4'h1;
                    end
                end
                default: begin
                    state <= fgra_pkg::fgra_st_idle;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // A word is committed only at the second byte of each data byte pair; a stop after one byte drops it.
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_word <= 16'h0000;
        end else begin
            wr_en <= scl_fall & ~start & ~stop & have_hi & (cnt == 4'h8) &
                     (state == fgra_pkg::fgra_st_wdata);
            wr_addr <= {ptr[7:1], 1'b0};
            wr_word <= {hi, shreg};
        end
    end

    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            restart_sense <= 1'b0;
        end else begin
            restart_sense <= pins.rise[`FGRA_PIN_QS] |
                (wr_en && wr_addr == `FGRA_OFS_CONTROL && wr_word == `FGRA_CMD_QUICK_SENSE);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            device_init <= 1'b0;
        end else begin
            device_init <= wr_en && wr_addr == `FGRA_OFS_FACTORY && wr_word == `FGRA_CMD_INIT;
        end
    end

    // ----------------------------------------------------------------
    // Configuration
    // ----------------------------------------------------------------
    assign wr_config = wr_en && wr_addr == `FGRA_OFS_COMP;
    assign wr_status = wr_en && wr_addr == `FGRA_OFS_STATUS;

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            compensation_param <= `FGRA_RST_COMP;
            sleep_mode <= 1'b0;
            step_en <= 1'b0;
            thr <= `FGRA_RST_THR;
        end else if (wr_config) begin
            compensation_param <= wr_word[15:8];
            sleep_mode <= wr_word[`FGRA_BIT_SLEEP];
            step_en <= wr_word[`FGRA_BIT_STEP_EN];
            thr <= wr_word[4:0];
        end
    end

    // ----------------------------------------------------------------
    // Status flags and alert
    // ----------------------------------------------------------------
    assign low_pct = `FGRA_THR_BASE - {3'b000, thr};
    assign below = charge_level < low_pct;
    assign set_step = step_en & charge_step_event;
    assign set_low = below & ~below_q;

    always_ff @(posedge mclk) begin
        if (rst_all) begin
            below_q <= 1'b0;
        end else begin
            below_q <= below;
        end
    end

    // Hardware sets win over a host clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            step_flag <= 1'b0;
            low_flag <= 1'b0;
            pup_flag <= 1'b1;
        end else begin
            step_flag <= set_step | (step_flag & ~(wr_status & ~wr_word[8 + `FGRA_BIT_STEP]));
            low_flag <= set_low | (low_flag & ~(wr_status & ~wr_word[8 + `FGRA_BIT_LOW]));
            pup_flag <= pup_flag & ~(wr_status & ~wr_word[8 + `FGRA_BIT_PUP]);
        end
    end

    // Sleep has no path into this flop, so sleeping never releases the pin.
    always_ff @(posedge mclk) begin
        if (rst_all) begin
            alert_sum <= 1'b0;
        end else begin
            alert_sum <= set_step | set_low | (alert_sum &
                ~(wr_config & ~wr_word[`FGRA_BIT_ALERT]) &
                ~(wr_status & ~wr_word[8 + `FGRA_BIT_STEP] & ~wr_word[8 + `FGRA_BIT_LOW]));
        end
    end

    assign alert_out = 1'b0;
    assign alert_oe = alert_sum;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        case (ptr)
            `FGRA_OFS_ID: rd_byte = ID_VALUE[15:8];
            `FGRA_OFS_ID + 8'h01: rd_byte = ID_VALUE[7:0];
            `FGRA_OFS_STATUS: begin
                rd_byte[`FGRA_BIT_STEP] = step_flag;
                rd_byte[`FGRA_BIT_LOW] = low_flag;
                rd_byte[`FGRA_BIT_PUP] = pup_flag;
            end
            `FGRA_OFS_RATE: rd_byte = charge_rate;
            `FGRA_OFS_COMP: rd_byte = compensation_param;
            `FGRA_OFS_CONFIG: rd_byte = {sleep_mode, step_en, alert_sum, thr};
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_qs_cmd;
        wr_en && wr_addr == `FGRA_OFS_CONTROL && wr_word == `FGRA_CMD_QUICK_SENSE && !device_init;
    endsequence
    sequence s_init_cmd;
        wr_en && wr_addr == `FGRA_OFS_FACTORY && wr_word == `FGRA_CMD_INIT;
    endsequence
    sequence s_por_state;
        pup_flag && compensation_param == `FGRA_RST_COMP && thr == `FGRA_RST_THR && !alert_sum;
    endsequence

    property p_qs_cmd;
        s_qs_cmd |=> restart_sense;
    endproperty
    a_qs_cmd: assert property (p_qs_cmd) else $error("quick sense not issued");

    property p_reserved_cmd;
        wr_en && wr_addr == `FGRA_OFS_CONTROL && wr_word != `FGRA_CMD_QUICK_SENSE &&
            !pins.rise[`FGRA_PIN_QS] |=> !restart_sense;
    endproperty
    a_reserved_cmd: assert property (p_reserved_cmd) else $error("reserved command acted");

    property p_id_read;
        ptr == `FGRA_OFS_ID |-> rd_byte == ID_VALUE[15:8];
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity changed");

    property p_status_layout;
        ptr == `FGRA_OFS_STATUS |-> rd_byte == {2'b00, step_flag, low_flag, 3'b000, pup_flag};
    endproperty
    a_status_layout: assert property (p_status_layout) else $error("status layout wrong");

    property p_cfg_write;
        wr_config && !device_init |=> compensation_param == $past(wr_word[15:8]) &&
            sleep_mode == $past(wr_word[7]) && step_en == $past(wr_word[6]) && thr == $past(wr_word[4:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_step_set;
        step_en && charge_step_event && !device_init |=> step_flag && alert_sum;
    endproperty
    a_step_set: assert property (p_step_set) else $error("step flag not set");

    property p_low_set;
        charge_level < low_pct && !below_q && !device_init |=> low_flag && alert_sum;
    endproperty
    a_low_set: assert property (p_low_set) else $error("low flag not set");

    property p_alert_sticky;
        alert_sum && !wr_en && !device_init |=> alert_sum && alert_oe;
    endproperty
    a_alert_sticky: assert property (p_alert_sticky) else $error("alert dropped");

    property p_init;
        s_init_cmd |=> device_init ##1 s_por_state;
    endproperty
    a_init: assert property (p_init) else $error("init not as power-on");

    property p_partial;
        stop && state == fgra_pkg::fgra_st_wdata && have_hi |=> !wr_en [*2];
    endproperty
    a_partial: assert property (p_partial) else $error("partial write committed");

    property p_foreign_addr;
        scl_fall && !start && !stop && state == fgra_pkg::fgra_st_addr && cnt == 4'h8 &&
            shreg[7:1] != `FGRA_SLAVE_ADDR |=> state == fgra_pkg::fgra_st_idle && !sda_oe;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked");
endmodule
`default_nettype wire

/* File: sim/fgra_host_model.sv */
// Host-side two-wire master model driving the gauge's bus pins.
// Assumes a pulled-up data line and a clock that stands high between frames.
`timescale 1ns/100ps
`default_nettype none
module fgra_host_model (
    input wire logic mclk,
    input wire logic sda_oe,
    output var logic scl,
    output logic sda
);
    logic sda_drv = 1'b1;
    initial scl = 1'b1;
    // The pull-up wins only when neither party pulls low.
    assign sda = sda_drv & ~sda_oe;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // One bus clock of 160 ns; data moves only while the clock is low.
    task automatic bit_io(input logic b, output logic s);
        scl <= 1'b0;
        tick(5);
        sda_drv <= b;
        tick(5);
        scl <= 1'b1;
        tick(5);
        s = sda;
        tick(5);
    endtask
    // Also serves as a repeated start.
    task automatic start();
        scl <= 1'b0;
        tick(5);
        sda_drv <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_drv <= 1'b0;
        tick(10);
    endtask
    task automatic stop();
        scl <= 1'b0;
        tick(5);
        sda_drv <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_drv <= 1'b1;
        tick(10);
    endtask
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(mack, ack);
    endtask
endmodule
`default_nettype wire

/* File: sim/fgra_testbench.sv */
// Self-checking bench for the gauge register block.
// Assumes the host model on the bus pins and a 125 MHz mclk.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // Arbitrary identity value.
    localparam logic [15:0] ID = 16'h2468;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic qs = 1'b0;
    logic ev = 1'b0;
    logic [7:0] level = 8'h32;
    logic [7:0] rate = 8'h2a;
    logic scl, sda, sda_oe, alert_oe, restart_sense, device_init, sleep_mode, a;
    logic sda_lvl, alert_lvl;
    logic [7:0] comp;
    logic [15:0] w;
    int fails = 0;
    int tests_run = 0;
    int rs_cnt = 0;
    int init_cnt = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        if (restart_sense === 1'b1)
            rs_cnt++;
        if (device_init === 1'b1)
            init_cnt++;
    end
    fgra_host_model fgra_host_model_i (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    fgra_gauge_regs #(.ID_VALUE(ID)) fgra_gauge_regs_i (.mclk(mclk), .reset(reset), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_lvl), .sda_oe(sda_oe), .restart_sense_input(qs), .alert_out(alert_lvl),
        .alert_oe(alert_oe), .charge_level(level), .charge_step_event(ev), .charge_rate(rate),
        .restart_sense(restart_sense), .device_init(device_init), .sleep_mode(sleep_mode),
        .compensation_param(comp));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        logic [7:0] q;
        fgra_host_model_i.xfer(b, 1'b1, q, a);
        check({15'h0, a}, 16'h0);
    endtask
    task automatic wr(input logic [7:0] r, input logic [15:0] d);
        fgra_host_model_i.start();
        send(8'h6c);
        send(r);
        send(d[15:8]);
        send(d[7:0]);
        fgra_host_model_i.stop();
    endtask
    task automatic rdchk(input logic [7:0] r, input logic [15:0] e);
        logic x;
        fgra_host_model_i.start();
        send(8'h6c);
        send(r);
        fgra_host_model_i.start();
        send(8'h6d);
        fgra_host_model_i.xfer(8'hff, 1'b0, w[15:8], x);
        fgra_host_model_i.xfer(8'hff, 1'b1, w[7:0], x);
        fgra_host_model_i.stop();
        check(w, e);
    endtask
    task automatic step();
        @(posedge mclk);
        ev <= 1'b1;
        @(posedge mclk);
        ev <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (5) @(posedge mclk);
        check({8'h0, comp}, 16'h0032);
        check({15'h0, alert_oe}, 16'h0);
        rdchk(8'h0c, 16'h321c);
        rdchk(8'h0a, 16'h012a);
        wr(8'h08, 16'h0000);
        rdchk(8'h08, ID);
        wr(8'h0c, 16'h5ac3);
        check({7'h0, sleep_mode, comp}, 16'h015a);
        wr(8'h0a, 16'h00ff);
        rdchk(8'h0a, 16'h002a);
        step();
        check({15'h0, alert_oe}, 16'h1);
        check({14'h0, sda_lvl, alert_lvl}, 16'h0);
        rdchk(8'h0a, 16'h202a);
        rdchk(8'h0c, 16'h5ae3);
        wr(8'h0a, 16'h0000);
        check({15'h0, alert_oe}, 16'h0);
        // Threshold field 03h means 29%, so 29 is not yet low.
        level <= 8'h1d;
        repeat (4) @(posedge mclk);
        rdchk(8'h0a, 16'h002a);
        level <= 8'h1c;
        repeat (4) @(posedge mclk);
        check({15'h0, alert_oe}, 16'h1);
        wr(8'h0c, 16'h5a03);
        check({14'h0, sleep_mode, alert_oe}, 16'h0);
        step();
        rdchk(8'h0a, 16'h102a);
        wr(8'h06, 16'h4000);
        check(16'(rs_cnt), 16'h1);
        wr(8'h06, 16'h4001);
        check(16'(rs_cnt), 16'h1);
        @(posedge mclk);
        qs <= 1'b1;
        repeat (10) @(posedge mclk);
        qs <= 1'b0;
        check(16'(rs_cnt), 16'h2);
        // A single data byte then stop must leave the register alone.
        fgra_host_model_i.start();
        send(8'h6c);
        send(8'h0c);
        send(8'h11);
        fgra_host_model_i.stop();
        rdchk(8'h0c, 16'h5a03);
        fgra_host_model_i.start();
        fgra_host_model_i.xfer(8'h6e, 1'b1, w[7:0], a);
        fgra_host_model_i.stop();
        check({15'h0, a}, 16'h1);
        level <= 8'h32;
        // The factory reset also clears the bus engine, so the last data byte goes unacknowledged.
        fgra_host_model_i.start();
        send(8'h6c);
        send(8'hfe);
        send(8'h54);
        fgra_host_model_i.xfer(8'h00, 1'b1, w[7:0], a);
        fgra_host_model_i.stop();
        check({15'h0, a}, 16'h1);
        check(16'(init_cnt), 16'h1);
        rdchk(8'h0c, 16'h321c);
        rdchk(8'h0a, 16'h012a);
        conclude();
    end
    initial begin
        #400000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
